// >>> include/mmt_pkg.sv
// register map, field positions, reset values and mode codes of the two-group timer
// assumes a 16-bit register port with word addresses and a single core clock
package mmt_pkg;

  // register port widths
  localparam int unsigned MMT_AW = 4;
  localparam int unsigned MMT_DW = 16;

  // register word addresses
  localparam logic [3:0] MMT_TA_CNT  = 4'h0;  // first group counter / reload
  localparam logic [3:0] MMT_TA_CTL  = 4'h1;  // first group control
  localparam logic [3:0] MMT_TB_CNT  = 4'h2;  // second group counter / reload
  localparam logic [3:0] MMT_TB_CTL  = 4'h3;  // second group control
  localparam logic [3:0] MMT_IRQ_STS = 4'h4;  // sticky status, read only
  localparam logic [3:0] MMT_IRQ_CLR = 4'h5;  // write one to clear, write only
  localparam logic [3:0] MMT_IRQ_EN  = 4'h6;  // interrupt enable

  // control field positions (both groups)
  localparam int unsigned MMT_CTL_START   = 0;
  localparam int unsigned MMT_CTL_MODE_LO = 1;
  localparam int unsigned MMT_CTL_MODE_HI = 2;
  localparam int unsigned MMT_CTL_REQ     = 3;
  localparam int unsigned MMT_CTL_UP      = 4;  // first group, event count direction
  localparam int unsigned MMT_CTL_MSEL_LO = 4;  // second group, measurement select
  localparam int unsigned MMT_CTL_MSEL_HI = 5;
  localparam int unsigned MMT_CTL_W       = 8;

  // status bit positions
  localparam int unsigned MMT_STS_TA = 0;
  localparam int unsigned MMT_STS_TB = 1;
  localparam int unsigned MMT_STS_W  = 2;

  // reset values
  localparam logic [15:0] MMT_CNT_RST = 16'h0000;
  localparam logic [7:0]  MMT_CTL_RST = 8'h00;
  localparam logic [1:0]  MMT_STS_RST = 2'h0;

  // values seen by a read that meets a reload
  localparam logic [15:0] MMT_ALL_ONES = 16'hffff;
  localparam logic [15:0] MMT_ALL_ZERO = 16'h0000;

  // first group operating modes
  typedef enum logic [1:0] {
    MMT_A_TIMER   = 2'b00,
    MMT_A_EVENT   = 2'b01,
    MMT_A_ONESHOT = 2'b10,
    MMT_A_PWM     = 2'b11
  } mmt_a_mode_t;

  // second group operating modes, code 11 is unused
  typedef enum logic [1:0] {
    MMT_B_TIMER = 2'b00,
    MMT_B_EVENT = 2'b01,
    MMT_B_MEAS  = 2'b10
  } mmt_b_mode_t;

  // measurement select codes
  localparam logic [1:0] MMT_MSEL_FALL = 2'b00;  // period, falling to falling
  localparam logic [1:0] MMT_MSEL_RISE = 2'b01;  // period, rising to rising

endpackage

// >>> include/mmt_tb_if.sv
// carrier between the register front end and the second group channel
// assumes both ends run on the same core clock
`timescale 1ns/100ps
`default_nettype none
interface mmt_tb_if;
  import mmt_pkg::*;
  logic              wr_cnt;      // counter register write strobe
  logic              wr_ctl;      // control register write strobe
  logic [15:0]       wdata;       // write data
  logic [15:0]       rd_val;      // value a counter read returns now
  logic [7:0]        ctl;         // control register readback
  logic              irq_set;     // one-cycle request event

  // front end side
  modport host (output wr_cnt, output wr_ctl, output wdata,
                input rd_val, input ctl, input irq_set);
  // channel side
  modport chan (input wr_cnt, input wr_ctl, input wdata,
                output rd_val, output ctl, output irq_set);
endinterface
`default_nettype wire

// >>> rtl/mmt_tb_chan.sv
// second group channel: timer, event counter and pulse period or width measurement
// assumes an asynchronous event pin and strobes from the front end on core_clk
`timescale 1ns/100ps
`default_nettype none
module mmt_tb_chan
  import mmt_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic evt_pin,
  mmt_tb_if.chan    bus
);

  logic        s1_q, s2_q, s3_q;     // pin synchroniser
  logic        lvl_q, lvl_d;         // accepted pin level
  logic [15:0] cnt_q, cnt_d;         // live counter
  logic [15:0] rld_q, rld_d;         // reload / measurement result
  logic [7:0]  ctl_q, ctl_d;         // control register
  logic        first_q, first_d;     // waiting for first measuring edge
  logic        set_q, set_d;         // request event towards status
  logic        ones_d;               // reload happens this cycle
  logic        rise, fall, eff;
  mmt_b_mode_t mode;

  // pin passes three flops; s1 feeds only s2
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= evt_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // next state of the channel
  always_comb begin
    lvl_d   = (s2_q == s3_q) ? s3_q : lvl_q;
    rise    = lvl_d & ~lvl_q;
    fall    = ~lvl_d & lvl_q;
    mode    = mmt_b_mode_t'(ctl_q[MMT_CTL_MODE_HI:MMT_CTL_MODE_LO]);
    // period modes take one edge, width takes both
    unique case (ctl_q[MMT_CTL_MSEL_HI:MMT_CTL_MSEL_LO])
      MMT_MSEL_FALL: eff = fall;
      MMT_MSEL_RISE: eff = rise;
      default:       eff = rise | fall;
    endcase
    cnt_d   = cnt_q;
    rld_d   = rld_q;
    ctl_d   = ctl_q;
    first_d = first_q;
    set_d   = 1'b0;
    ones_d  = 1'b0;
    if (ctl_q[MMT_CTL_START]) begin
      unique case (mode)
        MMT_B_TIMER, MMT_B_EVENT: begin
          // timer counts every clock, event counter on accepted edges
          if (mode == MMT_B_TIMER || eff) begin
            if (cnt_q == MMT_ALL_ZERO) begin
              cnt_d  = rld_q;
              set_d  = 1'b1;
              ones_d = 1'b1;
            end else begin
              cnt_d = cnt_q - 16'h0001;
            end
          end
        end
        MMT_B_MEAS: begin
          cnt_d = cnt_q + 16'h0001;
          if (eff) begin
            rld_d   = cnt_q;
            cnt_d   = MMT_ALL_ZERO;
            set_d   = ~first_q;
            first_d = 1'b0;
          end
        end
        default: cnt_d = cnt_q;  // unused code holds the counter
      endcase
    end
    if (bus.wr_cnt) begin
      rld_d = bus.wdata;
      if (!ctl_q[MMT_CTL_START]) begin
        cnt_d = bus.wdata;
      end
    end
    if (bus.wr_ctl) begin
      ctl_d = bus.wdata[7:0];
      // a fresh start arms the silent first edge
      if (bus.wdata[MMT_CTL_START] && !ctl_q[MMT_CTL_START]) begin
        first_d = 1'b1;
        // judge the mode being written, not the one it replaces
        cnt_d   = (mmt_b_mode_t'(bus.wdata[MMT_CTL_MODE_HI:MMT_CTL_MODE_LO]) == MMT_B_MEAS) ?
                  MMT_ALL_ZERO : cnt_d;
      end
      if (ctl_q[MMT_CTL_START] && mode == MMT_B_MEAS &&
          bus.wdata[MMT_CTL_MSEL_HI:MMT_CTL_MSEL_LO] !=
          ctl_q[MMT_CTL_MSEL_HI:MMT_CTL_MSEL_LO]) begin
        set_d = 1'b1;
      end
    end
    if (set_d) begin
      ctl_d[MMT_CTL_REQ] = 1'b1;
    end
  end

  // channel registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lvl_q   <= 1'b0;
      cnt_q   <= MMT_CNT_RST;
      rld_q   <= MMT_CNT_RST;
      ctl_q   <= MMT_CTL_RST;
      first_q <= 1'b0;
      set_q   <= 1'b0;
    end else begin
      lvl_q   <= lvl_d;
      cnt_q   <= cnt_d;
      rld_q   <= rld_d;
      ctl_q   <= ctl_d;
      first_q <= first_d;
      set_q   <= set_d;
    end
  end

  assign bus.rd_val  = (mode == MMT_B_MEAS) ? rld_q : (ones_d ? MMT_ALL_ONES : cnt_q);
  assign bus.ctl     = ctl_q;
  assign bus.irq_set = set_q;

endmodule
`default_nettype wire

// >>> rtl/mmt_top.sv
// two-group multi-mode timer: first group channel, second group channel, interrupts
// assumes a one-cycle strobe register port on core_clk and asynchronous event pins
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module mmt_top
  import mmt_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        ta_event_pin,
  input  wire logic        tb_event_pin,
  output logic             first_group_pulse_output,
  output logic             irq
);

  // register port decode
  logic        wr_ta_cnt, wr_ta_ctl, wr_tb_cnt, wr_tb_ctl, wr_clr, wr_en;

  // first group channel state
  logic        s1_q, s2_q, s3_q;         // event pin synchroniser
  logic        lvl_q, lvl_d;             // accepted event level
  logic        ev_edge;                  // accepted rising edge
  logic [15:0] cnt_q, cnt_d;             // live counter
  logic [15:0] rld_q, rld_d;             // reload register
  logic [7:0]  ctl_q, ctl_d;             // control register
  logic        run_q, run_d;             // one-shot in progress
  logic        out_q, out_d;             // pulse output level
  logic        set_a;                    // request event this cycle
  logic        rl_ones, rl_zero;         // reload happens this cycle
  logic        stop_a, go_a;             // start flag falling / rising by write
  mmt_a_mode_t mode, mode_new;

  // interrupt block
  logic [1:0]  sts_q, sts_d;             // sticky status
  logic [1:0]  en_q, en_d;               // enable mask
  logic        irq_d;
  logic [15:0] rdata_d;

  // second group channel carrier
  mmt_tb_if tb_bus ();

  // write strobes by address
  always_comb begin
    wr_ta_cnt = reg_wr && (reg_addr == MMT_TA_CNT);
    wr_ta_ctl = reg_wr && (reg_addr == MMT_TA_CTL);
    wr_tb_cnt = reg_wr && (reg_addr == MMT_TB_CNT);
    wr_tb_ctl = reg_wr && (reg_addr == MMT_TB_CTL);
    wr_clr    = reg_wr && (reg_addr == MMT_IRQ_CLR);
    wr_en     = reg_wr && (reg_addr == MMT_IRQ_EN);
  end

  assign tb_bus.wr_cnt = wr_tb_cnt;
  assign tb_bus.wr_ctl = wr_tb_ctl;
  assign tb_bus.wdata  = reg_wdata;

  // second group lives in its own module
  mmt_tb_chan u_tb (
    .core_clk (core_clk),
    .rst      (rst),
    .evt_pin  (tb_event_pin),
    .bus      (tb_bus)
  );

  // event pin: three flops, s1 feeds only s2
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= ta_event_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // next state of the first group channel
  always_comb begin
    // a level change counts once the second and third flops agree
    lvl_d    = (s2_q == s3_q) ? s3_q : lvl_q;
    ev_edge  = lvl_d & ~lvl_q;
    mode     = mmt_a_mode_t'(ctl_q[MMT_CTL_MODE_HI:MMT_CTL_MODE_LO]);
    mode_new = mmt_a_mode_t'(reg_wdata[MMT_CTL_MODE_HI:MMT_CTL_MODE_LO]);
    stop_a   = wr_ta_ctl && !reg_wdata[MMT_CTL_START] && ctl_q[MMT_CTL_START];
    go_a     = wr_ta_ctl && reg_wdata[MMT_CTL_START] && !ctl_q[MMT_CTL_START];
    cnt_d    = cnt_q;
    rld_d    = rld_q;
    ctl_d    = ctl_q;
    run_d    = run_q;
    out_d    = out_q;
    set_a    = 1'b0;
    rl_ones  = 1'b0;
    rl_zero  = 1'b0;
    if (ctl_q[MMT_CTL_START]) begin
      unique case (mode)
        MMT_A_TIMER: begin
          if (cnt_q == MMT_ALL_ZERO) begin
            cnt_d   = rld_q;
            set_a   = 1'b1;
            rl_ones = 1'b1;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
        MMT_A_EVENT: begin
          if (ev_edge) begin
            if (ctl_q[MMT_CTL_UP]) begin
              if (cnt_q == MMT_ALL_ONES) begin
                cnt_d   = rld_q;
                set_a   = 1'b1;
                rl_zero = 1'b1;
              end else begin
                cnt_d = cnt_q + 16'h0001;
              end
            end else if (cnt_q == MMT_ALL_ZERO) begin
              cnt_d   = rld_q;
              set_a   = 1'b1;
              rl_ones = 1'b1;
            end else begin
              cnt_d = cnt_q - 16'h0001;
            end
          end
        end
        MMT_A_ONESHOT: begin
          // output is high for the whole count, request at the end
          if (run_q) begin
            if (cnt_q == MMT_ALL_ZERO) begin
              cnt_d = rld_q;
              run_d = 1'b0;
              out_d = 1'b0;
              set_a = 1'b1;
            end else begin
              cnt_d = cnt_q - 16'h0001;
            end
          end
        end
        MMT_A_PWM: begin
          // high phase lasts the reload count, low phase its complement
          if (cnt_q == MMT_ALL_ZERO) begin
            if (out_q) begin
              out_d = 1'b0;
              cnt_d = ~rld_q;
              set_a = 1'b1;
            end else begin
              out_d = 1'b1;
              cnt_d = rld_q;
            end
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      endcase
    end
    if (wr_ta_cnt) begin
      rld_d = reg_wdata;
      if (!ctl_q[MMT_CTL_START]) begin
        cnt_d = reg_wdata;
      end
    end
    if (wr_ta_ctl) begin
      ctl_d = reg_wdata[7:0];
      // a start in one-shot or modulation begins a high phase from reload
      if (go_a && (mode_new == MMT_A_ONESHOT || mode_new == MMT_A_PWM)) begin
        cnt_d = rld_q;
        out_d = 1'b1;
        run_d = (mode_new == MMT_A_ONESHOT);
      end
      if (mode_new == MMT_A_ONESHOT &&
          (mode == MMT_A_TIMER || mode == MMT_A_EVENT)) begin
        set_a = 1'b1;
      end
      if (mode_new == MMT_A_PWM &&
          (mode == MMT_A_TIMER || mode == MMT_A_EVENT)) begin
        set_a = 1'b1;
      end
      if (stop_a && mode == MMT_A_ONESHOT && run_q) begin
        cnt_d = rld_q;
        run_d = 1'b0;
        out_d = 1'b0;
        set_a = 1'b1;
      end
      if (stop_a && mode == MMT_A_PWM) begin
        out_d = 1'b0;
        if (out_q) begin
          set_a = 1'b1;
        end
      end
    end
    if (set_a) begin
      ctl_d[MMT_CTL_REQ] = 1'b1;
    end
  end

  // first group registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lvl_q <= 1'b0;
      cnt_q <= MMT_CNT_RST;
      rld_q <= MMT_CNT_RST;
      ctl_q <= MMT_CTL_RST;
      run_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      rld_q <= rld_d;
      ctl_q <= ctl_d;
      run_q <= run_d;
      out_q <= out_d;
    end
  end

  // interrupt status, enable, output and read data
  always_comb begin
    // events set, write-one clears; a set in the same cycle wins
    sts_d = sts_q;
    if (wr_clr) begin
      sts_d = sts_q & ~reg_wdata[MMT_STS_W-1:0];
    end
    sts_d[MMT_STS_TA] = sts_d[MMT_STS_TA] | set_a;
    sts_d[MMT_STS_TB] = sts_d[MMT_STS_TB] | tb_bus.irq_set;
    en_d  = wr_en ? reg_wdata[MMT_STS_W-1:0] : en_q;
    irq_d = |(sts_d & en_d);
    rdata_d = MMT_ALL_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        MMT_TA_CNT: begin
          // the read meeting a reload sees the reload marker, not the count
          if (rl_ones) begin
            rdata_d = MMT_ALL_ONES;
          end else if (rl_zero) begin
            rdata_d = MMT_ALL_ZERO;
          end else begin
            rdata_d = cnt_q;
          end
        end
        MMT_TA_CTL:  rdata_d = {8'h00, ctl_q};
        MMT_TB_CNT:  rdata_d = tb_bus.rd_val;
        MMT_TB_CTL:  rdata_d = {8'h00, tb_bus.ctl};
        MMT_IRQ_STS: rdata_d = {14'h0000, sts_q};
        MMT_IRQ_EN:  rdata_d = {14'h0000, en_q};
        default:     rdata_d = MMT_ALL_ZERO;  // unmapped and write-only read zero
      endcase
    end
  end

  // interrupt and port registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sts_q     <= MMT_STS_RST;
      en_q      <= MMT_STS_RST;
      irq       <= 1'b0;
      reg_rdata <= MMT_ALL_ZERO;
    end else begin
      sts_q     <= sts_d;
      en_q      <= en_d;
      irq       <= irq_d;
      reg_rdata <= rdata_d;
    end
  end

  // pulse pin comes straight from its flop
  assign first_group_pulse_output = out_q;

endmodule
`default_nettype wire

// >>> testbench/mmt_pins.sv
// pin partner: event sources for both timer groups
// assumes the bench calls its task right after a rising core_clk edge
`timescale 1ns/100ps
`default_nettype none
module mmt_pins (
  input  wire logic core_clk,
  input  wire logic ta_run,
  output logic      ta_pin,
  output logic      tb_pin
);
  // both pins idle at time zero; the second one rests high
  initial begin
    ta_pin = 1'b0;
    tb_pin = 1'b1;
  end
  logic ph = 1'b0;  // halves the toggle rate of the square wave
  // square wave: one rising edge every four clocks while enabled; each level
  // stands two clocks, or the second and third sampling flops never agree
  always @(posedge core_clk) begin
    if (ta_run) begin
      ph <= ~ph;
      if (ph) begin
        ta_pin <= ~ta_pin;
      end
    end
  end
  // one falling edge after gap clocks, back high gap clocks later
  task automatic tb_fall(input int gap);
    repeat (gap) @(posedge core_clk);
    tb_pin <= 1'b0;
    repeat (gap) @(posedge core_clk);
    tb_pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> testbench/mmt_top_chk.sv
// concurrent checks on the timer's register port, pulse pin and interrupt
// assumes it is bound into mmt_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module mmt_top_chk
  import mmt_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        ta_event_pin,
  input wire logic        tb_event_pin,
  input wire logic        first_group_pulse_output,
  input wire logic        irq
);
  logic       ta_wr, tb_wr;    // control writes of each group
  logic [1:0] en_q, en_d;      // shadow of the interrupt enable
  logic [1:0] mode_q, mode_d;  // shadow of the first group mode
  logic       go_q, go_d;      // shadow of the first group start
  logic [7:0] bctl_q, bctl_d;  // shadow of the second group control
  assign ta_wr = reg_wr && reg_addr == MMT_TA_CTL;
  assign tb_wr = reg_wr && reg_addr == MMT_TB_CTL;
  // shadows follow software only; a finished one-shot is not mirrored
  always_comb begin
    en_d   = (reg_wr && reg_addr == MMT_IRQ_EN) ? reg_wdata[1:0] : en_q;
    mode_d = ta_wr ? reg_wdata[2:1] : mode_q;
    go_d   = ta_wr ? reg_wdata[0] : go_q;
    bctl_d = tb_wr ? reg_wdata[7:0] : bctl_q;
  end
  always_ff @(posedge core_clk) begin
    en_q   <= rst ? 2'h0 : en_d;
    mode_q <= rst ? 2'h0 : mode_d;
    go_q   <= rst ? 1'b0 : go_d;
    bctl_q <= rst ? 8'h00 : bctl_d;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // software stop of the first group while it sits in mode m
  sequence stop_s(logic [1:0] m);
    ta_wr && mode_q == m && reg_wdata[2:1] == m && !reg_wdata[0];
  endsequence
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  os_stop_low_a: assert property (stop_s(2'b10) |=> !first_group_pulse_output)
    else $error("one-shot stop left the pulse high");
  os_stop_req_a: assert property (stop_s(2'b10) ##0 (first_group_pulse_output && en_q[0]) |=> irq)
    else $error("one-shot stop raised no request");
  pwm_stop_req_a: assert property (stop_s(2'b11) ##0
    (first_group_pulse_output && en_q[0]) |=> irq && !first_group_pulse_output)
    else $error("modulation stop from high is wrong");
  pwm_low_quiet_a: assert property (stop_s(2'b11) ##0
    (!first_group_pulse_output && !irq && en_q == 2'b01) |=> !irq [*2])
    else $error("modulation stop from low raised a request");
  os_enter_req_a: assert property (ta_wr && !mode_q[1]
    && reg_wdata[2:1] == 2'b10 && en_q[0] |=> irq)
    else $error("entering one-shot set no request");
  pwm_enter_req_a: assert property (ta_wr && !mode_q[1]
    && reg_wdata[2:1] == 2'b11 && en_q[0] |=> irq)
    else $error("entering modulation set no request");
  // the second group's event is registered in its channel, so status and irq lag one clock
  msel_req_a: assert property (tb_wr && bctl_q[2:0] == 3'b101
    && reg_wdata[2:0] == 3'b101 && reg_wdata[5:4] != bctl_q[5:4] && en_q[1] |-> ##2 irq)
    else $error("measurement select change set no request");
  halt_low_a: assert property (!go_q |-> !first_group_pulse_output)
    else $error("pulse high while the first group is stopped");
  irq_mask_a: assert property (reg_wr && reg_addr == MMT_IRQ_EN
    && reg_wdata[1:0] == 2'b00 |=> !irq)
    else $error("interrupt high with all sources disabled");
endmodule
`default_nettype wire

// >>> testbench/tb_mmt_top.sv
// bench for the two-group timer: register tasks, read checker, scenarios
// assumes the pin partner mmt_pins and the checker mmt_top_chk
`timescale 1ns/100ps
`default_nettype none
module tb_mmt_top;
  import mmt_pkg::*;
  typedef struct {logic [17:0] e; logic [17:0] m; bit lv;} mmt_note_t;
  localparam logic [17:0] m_all = 18'h3ffff;  // irq, pulse and data
  localparam logic [17:0] m_nop = 18'h2ffff;  // pulse not judged
  localparam logic [17:0] m_dat = 18'h0ffff;  // data only
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ta_run = 1'b0;
  logic        rd_q = 1'b0;
  logic [15:0] reg_rdata, rv;
  logic        ta_pin, tb_pin, pulse, irq;
  mmt_note_t   notes[$];
  mmt_note_t   nt;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n_ones = 0;
  int          n_zero = 0;
  int          seed = 20308;
  initial forever #50 core_clk = ~core_clk;
  mmt_top u_mmt_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ta_event_pin(ta_pin), .tb_event_pin(tb_pin), .first_group_pulse_output(pulse), .irq(irq));
  mmt_pins u_mmt_pins (.core_clk(core_clk), .ta_run(ta_run), .ta_pin(ta_pin), .tb_pin(tb_pin));
  // one bus cycle; strobes stay until the next call, so end with idle
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  // note holds {irq, pulse, data}; m masks what is judged
  task automatic rd(input logic [3:0] a, input logic [17:0] e, input logic [17:0] m);
    notes.push_back('{e, m, 1'b0});
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask
  // back-to-back reads of a running count, at most lim or a reload value
  task automatic live(input logic [3:0] a, input logic [15:0] lim, input int n);
    repeat (n) begin
      notes.push_back('{{2'b00, lim}, 18'h0, 1'b1});
      bus(1'b0, 1'b1, a, 16'h0000);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // answer stands in the cycle after the strobe, judged at its end
  always @(posedge core_clk) begin
    if (rd_q && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.lv) begin
        n_ones += (reg_rdata === 16'hffff);
        n_zero += (reg_rdata === 16'h0000);
        chk(reg_rdata <= nt.e[15:0] || reg_rdata === 16'hffff || reg_rdata === 16'h0000, "live");
      end else chk((({irq, pulse, reg_rdata} ^ nt.e) & nt.m) === 18'h0, "register read");
    end
    rd_q <= reg_rd;
  end
  // watchdog: the whole run needs well under 2000 clocks
  initial begin
    repeat (6000) @(posedge core_clk);
    n_mismatch++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, unmapped and one-way places
    rd(MMT_TA_CTL, 18'h0, m_all);
    rd(MMT_TB_CTL, 18'h0, m_all);
    wr(MMT_IRQ_STS, 16'hffff);
    rd(MMT_IRQ_STS, 18'h0, m_all);
    rd(MMT_IRQ_CLR, 18'h0, m_all);
    for (int a = 7; a < 16; a++) begin
      wr(4'(a), 16'hffff);
      rd(4'(a), 18'h0, m_all);
    end
    // halted counters hand back what was written
    repeat (3) begin
      rv = 16'($random(seed));
      wr(MMT_TA_CNT, rv);
      rd(MMT_TA_CNT, {2'b00, rv}, m_dat);
      wr(MMT_TB_CNT, ~rv);
      rd(MMT_TB_CNT, {2'b00, ~rv}, m_dat);
    end
    $display("test registers done");
    // timer mode: period six, two reload reads in twelve
    wr(MMT_TA_CNT, 16'h0005);
    wr(MMT_TA_CTL, 16'h0001);
    idle(3);
    n_ones = 0;
    live(MMT_TA_CNT, 16'h0005, 12);
    idle(2);
    chk(n_ones === 2, "timer reload reads");
    wr(MMT_TA_CTL, 16'h0000);
    // event mode down then up, an edge every four clocks, a reload every eight
    wr(MMT_TA_CNT, 16'h0001);
    wr(MMT_TA_CTL, 16'h0003);
    ta_run <= 1'b1;
    idle(10);
    n_ones = 0;
    live(MMT_TA_CNT, 16'h0001, 16);
    idle(2);
    chk(n_ones === 2, "underflow reload reads");
    wr(MMT_TA_CTL, 16'h0002);
    wr(MMT_TA_CNT, 16'hfffe);
    wr(MMT_TA_CTL, 16'h0013);
    idle(10);
    n_zero = 0;
    live(MMT_TA_CNT, 16'hffff, 16);
    idle(2);
    chk(n_zero === 2, "overflow reload reads");
    ta_run <= 1'b0;
    wr(MMT_TA_CTL, 16'h0000);
    // second group timer: period four
    wr(MMT_TB_CNT, 16'h0003);
    wr(MMT_TB_CTL, 16'h0001);
    idle(3);
    n_ones = 0;
    live(MMT_TB_CNT, 16'h0003, 8);
    idle(2);
    chk(n_ones === 2, "second group reload reads");
    wr(MMT_TB_CTL, 16'h0000);
    $display("test live reads done");
    // entering one-shot or modulation from timer or event mode
    wr(MMT_IRQ_EN, 16'h0003);
    for (int s = 0; s < 2; s++) begin
      for (int d = 2; d < 4; d++) begin
        wr(MMT_TA_CTL, 16'(s << 1));
        wr(MMT_IRQ_CLR, 16'h0003);
        wr(MMT_TA_CTL, 16'(d << 1));
        rd(MMT_TA_CTL, {2'b10, 12'h000, 4'(8 + 2 * d)}, m_nop);
      end
    end
    wr(MMT_TA_CTL, 16'h0000);
    wr(MMT_IRQ_CLR, 16'h0003);
    rd(MMT_IRQ_STS, 18'h0, m_nop);
    $display("test mode entry done");
    // one-shot stopped early
    wr(MMT_TA_CNT, 16'h0100);
    wr(MMT_TA_CTL, 16'h0004);
    wr(MMT_TA_CTL, 16'h0004);
    rd(MMT_TA_CTL, 18'h00004, m_dat);
    wr(MMT_IRQ_CLR, 16'h0003);
    wr(MMT_TA_CTL, 16'h0005);
    rd(MMT_TA_CNT, 18'h10000, 18'h30000);
    idle(5);
    wr(MMT_TA_CTL, 16'h0004);
    rd(MMT_TA_CNT, 18'h20100, m_all);
    rd(MMT_TA_CTL, 18'h2000c, m_all);
    wr(MMT_TA_CTL, 16'h0000);
    $display("test one-shot done");
    // modulation stopped while high
    wr(MMT_TA_CNT, 16'h0040);
    wr(MMT_TA_CTL, 16'h0006);
    wr(MMT_TA_CTL, 16'h0006);
    wr(MMT_IRQ_CLR, 16'h0003);
    wr(MMT_TA_CTL, 16'h0007);
    rd(MMT_IRQ_STS, 18'h10000, m_all);
    wr(MMT_TA_CTL, 16'h0006);
    rd(MMT_IRQ_STS, 18'h20001, m_all);
    // modulation stopped while low: silent
    wr(MMT_IRQ_EN, 16'h0001);
    wr(MMT_TA_CNT, 16'h0002);
    wr(MMT_TA_CTL, 16'h0007);
    idle(1);
    for (int i = 0; i < 20 && pulse !== 1'b0; i++) idle(1);
    wr(MMT_TA_CTL, 16'h0007);
    wr(MMT_IRQ_CLR, 16'h0003);
    wr(MMT_TA_CTL, 16'h0006);
    rd(MMT_IRQ_STS, 18'h0, m_all);
    $display("test modulation done");
    // measurement: first edge silent, second one requests
    wr(MMT_IRQ_EN, 16'h0003);
    wr(MMT_TB_CTL, 16'h0005);
    idle(1);
    u_mmt_pins.tb_fall(8);
    idle(4);
    rd(MMT_IRQ_STS, 18'h0, m_nop);
    idle(1);
    u_mmt_pins.tb_fall(20);
    idle(4);
    rd(MMT_IRQ_STS, 18'h20002, m_nop);
    // select change while measuring
    wr(MMT_IRQ_CLR, 16'h0003);
    wr(MMT_TB_CTL, 16'h0015);
    rd(MMT_TB_CTL, 18'h2001d, m_nop);
    wr(MMT_IRQ_EN, 16'h0000);
    rd(MMT_IRQ_STS, 18'h00002, m_nop);
    wr(MMT_TB_CTL, 16'h0000);
    idle(3);
    $display("test measurement done");
    finish_test;
  end
endmodule
bind mmt_top mmt_top_chk u_mmt_top_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ta_event_pin(ta_event_pin), .tb_event_pin(tb_event_pin),
  .first_group_pulse_output(first_group_pulse_output), .irq(irq));
`default_nettype wire
